// ==== adc_host_pkg.sv ====
// Constants and types for the converter host controller
package adc_host_pkg;
   // Device register addresses
   localparam logic [7:0] ADDR_CTRL0 = 8'h00;
   localparam logic [7:0] ADDR_CTRL1 = 8'h01;
   localparam logic [7:0] ADDR_CTRL2 = 8'h02;
   localparam logic [7:0] ADDR_CTRL3 = 8'h03;
   localparam logic [7:0] ADDR_CTRL4 = 8'h04;
   localparam logic [7:0] ADDR_CTRL5 = 8'h05;
   localparam logic [7:0] ADDR_RES_BASE = 8'h08;
   localparam logic [7:0] ADDR_RES_FIRST = 8'h08;
   localparam logic [7:0] ADDR_RES_SECOND = 8'h09;
   localparam logic [7:0] ADDR_INT_CTRL = 8'h10;
   localparam logic [7:0] ADDR_PORT_DIR = 8'h11;
   localparam logic [7:0] ADDR_ANALOG_SEL = 8'h12;
   localparam logic [7:0] ADDR_TRIG_DIR = 8'h13;
   // Bit positions
   localparam int C0_CH = 0;
   localparam int C0_MODE = 3;
   localparam int C0_TRIG = 5;
   localparam int C0_START = 6;
   localparam int C1_SWEEP = 0;
   localparam int C1_MODE_EXT = 2;
   localparam int C1_EXT_SEL = 4;
   localparam int C1_REF = 6;
   localparam int C2_SMP = 0;
   localparam int C2_GROUP = 1;
   localparam int C2_TSRC = 3;
   localparam int C3_DMA = 0;
   localparam int C3_MSS = 1;
   localparam int C5_EN = 0;
   localparam int C5_KIND = 1;
   localparam int C5_DIR = 2;
   localparam int INT_FLAG = 3;
   // Values written
   localparam logic [7:0] PORT_ALL_INPUT = 8'h00;
   localparam logic [7:0] ANALOG_ALL = 8'hFF;
   localparam logic [7:0] CONV_DIV_CODE = 8'h00;
   localparam logic [1:0] GROUP_BASIC = 2'h0;
   localparam logic [1:0] SWEEP_RESEL = 2'h0;
   // Timing
   localparam int CLK_PERIOD_NS = 100;
   localparam int REF_WAIT_NS = 1000;
   localparam int REF_WAIT_CYC = (REF_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SAMPLE_CYC_PLAIN = 2;
   localparam int SAMPLE_CYC_HOLD = 3;
   localparam int RD_LAT_CYC = 4;
   localparam logic [3:0] STEP_REF_ON = 4'hA;
   localparam logic [3:0] STEP_START = 4'hC;

   typedef enum logic [9:0] {
      ST_IDLE = 10'h001,
      ST_CFG = 10'h002,
      ST_REFW = 10'h004,
      ST_GO = 10'h008,
      ST_SAMP = 10'h010,
      ST_POLL = 10'h020,
      ST_RES = 10'h040,
      ST_CLR = 10'h080,
      ST_HALT = 10'h100,
      ST_PWR = 10'h200
   } state_t;
endpackage

// ==== adc_host_ctrl.sv ====
// Host sequencer that programs and reads the on-chip converter
`timescale 1ns/1ps
// What this block does
// - Group select 00, sweep off for extended
// - Wait 1 us after reference before start
// - Never join start and reference; no mid-run cut
// - Configure only while conversion stopped
// - Conversion clock kept within allowed band
// - Reselect pins after mode change
// - Read results only after request flag
// - Results undefined after a halt
// - No external trigger or reads under DMA
// - Disable interrupts before clearing start
// - Trigger pin made input for external trigger
// - Analog pins input and analog-selected
module adc_host_ctrl
(
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   // User orders
   input wire logic cmd_start_in,
   input wire logic cmd_halt_in,
   input wire logic cmd_power_down_in,
   input wire logic [1:0] cfg_ext_pin_sel_in,
   input wire logic [2:0] cfg_channel_in,
   input wire logic [2:0] cfg_op_mode_in,
   input wire logic cfg_dma_in,
   input wire logic cfg_sample_hold_in,
   input wire logic cfg_trigger_ext_in,
   input wire logic [1:0] cfg_trig_src_in,
   input wire logic cfg_assist_en_in,
   input wire logic cfg_assist_kind_in,
   input wire logic cfg_assist_dir_in,
   // User status
   output logic busy_out,
   output logic done_out,
   output logic running_out,
   output logic [15:0] result_out,
   output logic result_valid_out,
   output logic result_undefined_out,
   // Device register port
   output logic [7:0] dev_addr_out,
   output logic [7:0] dev_wdata_out,
   output logic dev_wr_out,
   output logic dev_rd_out,
   input wire logic [15:0] dev_rdata_in
);
   typedef struct packed {
      adc_host_pkg::state_t st;
      logic [3:0] step;
      logic [7:0] cnt;
      logic [7:0] since_ref;
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
      logic [15:0] s1;
      logic [15:0] s2;
      logic busy;
      logic done;
      logic rvalid;
      logic undef;
      logic running;
      logic flag_seen;
      logic int_off;
      logic [15:0] result;
      logic [1:0] ext;
      logic [2:0] ch;
      logic [2:0] mode;
      logic dma;
      logic smp;
      logic trig;
      logic [1:0] tsrc;
      logic ast_en;
      logic ast_kind;
      logic ast_dir;
   } ctl_t;

   ctl_t q;
   ctl_t d;

   // Address and data of each programming step
   function automatic logic [15:0] item(input logic [3:0] step, input ctl_t c);
      logic [7:0] a;
      logic [7:0] v;
      a = adc_host_pkg::ADDR_INT_CTRL;
      v = 8'h00;
      case (step)
         // flag cleared again once stopped
         // A conversion ending as the stop lands leaves a stale flag
         4'h0, 4'h2: a = adc_host_pkg::ADDR_INT_CTRL;
         4'h1: a = adc_host_pkg::ADDR_CTRL0;
         4'h3:
         begin
            a = adc_host_pkg::ADDR_CTRL2;
            v[adc_host_pkg::C2_SMP] = c.smp;
            v[adc_host_pkg::C2_GROUP +: 2] = adc_host_pkg::GROUP_BASIC;
            v[adc_host_pkg::C2_TSRC +: 2] = c.tsrc;
         end
         4'h4:
         begin
            a = adc_host_pkg::ADDR_CTRL3;
            v[adc_host_pkg::C3_DMA] = c.dma;
            v[adc_host_pkg::C3_MSS] = 1'b0;
         end
         4'h5:
         begin
            a = adc_host_pkg::ADDR_CTRL4;
            v = adc_host_pkg::CONV_DIV_CODE;
         end
         4'h6:
         begin
            a = adc_host_pkg::ADDR_CTRL5;
            v[adc_host_pkg::C5_EN] = c.ast_en;
            v[adc_host_pkg::C5_KIND] = c.ast_kind;
            v[adc_host_pkg::C5_DIR] = c.ast_dir;
         end
         4'h7: a = adc_host_pkg::ADDR_PORT_DIR;
         4'h8:
         begin
            a = adc_host_pkg::ADDR_ANALOG_SEL;
            v = adc_host_pkg::ANALOG_ALL;
         end
         4'h9: a = adc_host_pkg::ADDR_TRIG_DIR;
         4'hA:
         begin
            a = adc_host_pkg::ADDR_CTRL1;
            v[adc_host_pkg::C1_SWEEP +: 2] = adc_host_pkg::SWEEP_RESEL;
            v[adc_host_pkg::C1_MODE_EXT] = c.mode[2];
            v[adc_host_pkg::C1_EXT_SEL +: 2] = c.ext;
            v[adc_host_pkg::C1_REF] = 1'b1;
         end
         4'hB, 4'hC:
         begin
            a = adc_host_pkg::ADDR_CTRL0;
            v[adc_host_pkg::C0_CH +: 3] = c.ch;
            v[adc_host_pkg::C0_MODE +: 2] = c.mode[1:0];
            v[adc_host_pkg::C0_TRIG] = c.trig;
            v[adc_host_pkg::C0_START] = (step == adc_host_pkg::STEP_START);
         end
         default: a = adc_host_pkg::ADDR_INT_CTRL;
      endcase
      return {a, v};
   endfunction

   always_comb
   begin
      logic [15:0] it;
      it = 16'h0000;
      d = q;
      d.s1 = dev_rdata_in;
      d.s2 = q.s1;
      d.wr = 1'b0;
      d.rd = 1'b0;
      d.done = 1'b0;
      d.since_ref = (q.since_ref == 8'hFF) ? q.since_ref : q.since_ref + 8'h01;
      case (q.st)
         adc_host_pkg::ST_IDLE:
         begin
            if (cmd_start_in)
            begin
               d.ext = cfg_ext_pin_sel_in;
               d.ch = cfg_channel_in;
               d.mode = cfg_op_mode_in;
               d.dma = cfg_dma_in;
               d.smp = cfg_sample_hold_in;
               d.trig = cfg_trigger_ext_in & ~cfg_dma_in;
               d.tsrc = cfg_trig_src_in;
               d.ast_en = cfg_assist_en_in;
               d.ast_kind = cfg_assist_kind_in;
               d.ast_dir = cfg_assist_dir_in;
               d.step = 4'h0;
               d.busy = 1'b1;
               d.rvalid = 1'b0;
               d.st = adc_host_pkg::ST_CFG;
            end
            else if (cmd_halt_in && q.running)
            begin
               d.step = 4'h0;
               d.busy = 1'b1;
               d.st = adc_host_pkg::ST_HALT;
            end
            else if (cmd_power_down_in && !q.running)
            begin
               d.busy = 1'b1;
               d.st = adc_host_pkg::ST_PWR;
            end
         end
         adc_host_pkg::ST_CFG, adc_host_pkg::ST_GO:
         begin
            // stop is written before any config
            it = item(q.step, q);
            d.addr = it[15:8];
            d.wdata = it[7:0];
            d.wr = 1'b1;
            d.step = q.step + 4'h1;
            d.int_off = (it[15:8] == adc_host_pkg::ADDR_INT_CTRL);
            if (q.step == 4'h1 && q.running)
            begin
               d.running = 1'b0;
               d.undef = 1'b1;
            end
            if (q.step == adc_host_pkg::STEP_REF_ON)
            begin
               d.since_ref = 8'h00;
               d.st = adc_host_pkg::ST_REFW;
            end
            if (q.step == adc_host_pkg::STEP_START)
            begin
               d.running = 1'b1;
               d.undef = 1'b0;
               d.flag_seen = 1'b0;
               d.cnt = q.smp ? 8'(adc_host_pkg::SAMPLE_CYC_HOLD - 1)
                             : 8'(adc_host_pkg::SAMPLE_CYC_PLAIN - 1);
               d.st = adc_host_pkg::ST_SAMP;
            end
         end
         adc_host_pkg::ST_REFW:
         begin
            if (q.since_ref >= 8'(adc_host_pkg::REF_WAIT_CYC - 1))
               d.st = adc_host_pkg::ST_GO;
         end
         adc_host_pkg::ST_SAMP:
         begin
            d.cnt = q.cnt - 8'h01;
            if (q.cnt == 8'h00)
            begin
               d.addr = adc_host_pkg::ADDR_INT_CTRL;
               d.rd = 1'b1;
               d.cnt = 8'(adc_host_pkg::RD_LAT_CYC - 1);
               d.st = adc_host_pkg::ST_POLL;
            end
         end
         adc_host_pkg::ST_POLL:
         begin
            d.cnt = q.cnt - 8'h01;
            if (cmd_halt_in)
            begin
               d.step = 4'h0;
               d.st = adc_host_pkg::ST_HALT;
            end
            else if (q.cnt == 8'h00)
            begin
               d.cnt = 8'(adc_host_pkg::RD_LAT_CYC - 1);
               d.rd = 1'b1;
               // result read waits for the flag
               if (q.s2[adc_host_pkg::INT_FLAG])
               begin
                  d.flag_seen = 1'b1;
                  // results sit in first; left to DMA
                  if (q.dma)
                  begin
                     d.rd = 1'b0;
                     d.st = adc_host_pkg::ST_CLR;
                  end
                  else
                  begin
                     if (q.ext == 2'h1)
                        d.addr = adc_host_pkg::ADDR_RES_FIRST;
                     else if (q.ext == 2'h2)
                        d.addr = adc_host_pkg::ADDR_RES_SECOND;
                     else
                        d.addr = adc_host_pkg::ADDR_RES_BASE + {5'h00, q.ch};
                     d.st = adc_host_pkg::ST_RES;
                  end
               end
            end
         end
         adc_host_pkg::ST_RES:
         begin
            d.cnt = q.cnt - 8'h01;
            if (q.cnt == 8'h00)
            begin
               d.result = q.s2;
               d.rvalid = 1'b1;
               d.st = adc_host_pkg::ST_CLR;
            end
         end
         adc_host_pkg::ST_CLR:
         begin
            // Clearing the flag lets repeat modes flag again
            d.addr = adc_host_pkg::ADDR_INT_CTRL;
            d.wdata = 8'h00;
            d.wr = 1'b1;
            d.int_off = 1'b1;
            d.flag_seen = 1'b0;
            d.done = 1'b1;
            d.busy = 1'b0;
            d.st = adc_host_pkg::ST_IDLE;
         end
         adc_host_pkg::ST_HALT:
         begin
            it = item(q.step, q);
            d.addr = it[15:8];
            d.wdata = it[7:0];
            d.wr = 1'b1;
            d.int_off = (q.step == 4'h0);
            d.step = q.step + 4'h1;
            if (q.step == 4'h1)
            begin
               d.running = 1'b0;
               d.undef = 1'b1;
               d.rvalid = 1'b0;
               d.busy = 1'b0;
               d.st = adc_host_pkg::ST_IDLE;
            end
         end
         adc_host_pkg::ST_PWR:
         begin
            d.addr = adc_host_pkg::ADDR_CTRL1;
            d.wdata = 8'h00;
            d.wr = 1'b1;
            d.int_off = 1'b0;
            d.busy = 1'b0;
            d.st = adc_host_pkg::ST_IDLE;
         end
         default: d.st = adc_host_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         q <= '0;
         q.st <= adc_host_pkg::ST_IDLE;
         q.since_ref <= 8'hFF;
      end
      else
         q <= d;
   end

   assign busy_out = q.busy;
   assign done_out = q.done;
   assign running_out = q.running;
   assign result_out = q.result;
   assign result_valid_out = q.rvalid;
   assign result_undefined_out = q.undef;
   assign dev_addr_out = q.addr;
   assign dev_wdata_out = q.wdata;
   assign dev_wr_out = q.wr;
   assign dev_rd_out = q.rd;

   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!rst_n_in);

   localparam int REF_MIN = adc_host_pkg::REF_WAIT_CYC;

   ref_settle_a: assert property (q.wr && q.addr == adc_host_pkg::ADDR_CTRL0
      && q.wdata[adc_host_pkg::C0_START] |-> q.since_ref >= 8'(REF_MIN))
      else $error("start written too soon after reference");
   ref_cut_a: assert property (q.wr && q.addr == adc_host_pkg::ADDR_CTRL1
      && !q.wdata[adc_host_pkg::C1_REF] |-> !q.running && !$past(q.running))
      else $error("reference cut while running");
   cfg_stopped_a: assert property (q.wr && q.addr > adc_host_pkg::ADDR_CTRL0
      && q.addr <= adc_host_pkg::ADDR_CTRL5 |-> !q.running)
      else $error("configuration written while running");
   group_zero_a: assert property (q.wr && q.addr == adc_host_pkg::ADDR_CTRL2
      |-> q.wdata[adc_host_pkg::C2_GROUP +: 2] == 2'h0)
      else $error("group select not basic");
   result_flag_a: assert property (q.rd && q.addr >= adc_host_pkg::ADDR_RES_BASE
      && q.addr < adc_host_pkg::ADDR_INT_CTRL |-> q.flag_seen)
      else $error("result read before request flag");
   dma_no_read_a: assert property (q.dma && q.running |->
      !(q.rd && q.addr == adc_host_pkg::ADDR_RES_FIRST))
      else $error("program read of first result under DMA");
   int_off_halt_a: assert property ($past(q.running) && q.wr
      && q.addr == adc_host_pkg::ADDR_CTRL0 |-> $past(q.int_off))
      else $error("start cleared with interrupts live");
   halt_undef_a: assert property ($rose(q.undef) |-> !q.rvalid ##1 !q.rvalid)
      else $error("result valid after halt");
   sample_plain_a: assert property ($rose(q.running) && !q.smp |->
      !q.rd [*2] ##1 q.rd)
      else $error("poll ignores plain sampling window");
   sample_hold_a: assert property ($rose(q.running) && q.smp |->
      !q.rd [*3] ##1 q.rd)
      else $error("poll ignores held sampling window");

   start_run_c: cover property ($rose(q.running) ##[1:200] q.done && q.rvalid);
   halt_run_c: cover property (q.running ##1 !q.running && q.undef);
   dma_done_c: cover property (q.dma && q.done && !q.rvalid);
   power_down_c: cover property (q.st == adc_host_pkg::ST_PWR);
endmodule

// ==== adc_dev_model.sv ====
// Behavioural model of the converter device behind its register port
`timescale 1ns/1ps
module adc_dev_model
(
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   // Register port
   input wire logic [7:0] dev_addr_in,
   input wire logic [7:0] dev_wdata_in,
   input wire logic dev_wr_in,
   input wire logic dev_rd_in,
   output logic [15:0] dev_rdata_out,
   // Analog side
   input wire logic [9:0] level_in,
   input wire logic open_in,
   input wire logic slow_in,
   input wire logic trig_n_in,
   // Observation
   output logic ladder_on_out,
   output int viol_out
);
   logic [7:0] r_q [0:31];
   logic [15:0] res_q [0:7];
   logic trig_q;
   logic resel_q;
   int cnt_q;
   int age_q;
   int hold_q;
   int span;
   logic [2:0] idx;
   logic [15:0] val;
   wire logic start = r_q[0][adc_host_pkg::C0_START];
   wire logic dma_on = r_q[3][adc_host_pkg::C3_DMA];

   assign ladder_on_out = r_q[1][adc_host_pkg::C1_REF];
   // sampling window, slow sensors add settling
   assign span = (r_q[2][0] ? 3 : 2) + (slow_in ? 40 : 6);
   assign idx = dma_on ? 3'h0 : (r_q[1][5:4] == 2'h1) ? 3'h0 :
                (r_q[1][5:4] == 2'h2) ? 3'h1 : r_q[0][2:0];
   // assist pulls; open pin floats; no ladder gives junk
   assign val = !ladder_on_out ? 16'hFFFF :
                (r_q[5][0] && (r_q[5][1] || open_in)) ? (r_q[5][2] ? 16'h0000 : 16'h03FF) :
                {6'h00, open_in ? ~level_in : level_in};

   always @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         foreach (r_q[i]) r_q[i] <= 8'h00;
         foreach (res_q[i]) res_q[i] <= 16'h0000;
         trig_q <= 1'b1;
         resel_q <= 1'b0;
         cnt_q <= 0;
         age_q <= 0;
         hold_q <= 0;
         viol_out <= 0;
         dev_rdata_out <= 16'h0000;
      end
      else
      begin
         trig_q <= trig_n_in;
         age_q <= age_q + 1;
         if (hold_q > 0)
            hold_q <= hold_q - 1;
         // Released read data must not look stable
         if (hold_q == 1)
            dev_rdata_out <= ~dev_rdata_out;
         if (cnt_q > 0)
            cnt_q <= cnt_q - 1;
         if (cnt_q == 1)
         begin
            res_q[idx] <= val;
            r_q[adc_host_pkg::ADDR_INT_CTRL][adc_host_pkg::INT_FLAG] <= 1'b1;
            // flag per result, repeat keeps going
            if (r_q[0][4:3] == 2'h1)
               cnt_q <= span;
            else
               r_q[0][adc_host_pkg::C0_START] <= 1'b0;
         end
         if (start && r_q[0][5] && trig_q && !trig_n_in)
            cnt_q <= span;
         if (dev_wr_in)
         begin
            r_q[dev_addr_in[4:0]] <= dev_wdata_in;
            // channel rewritten after every mode write
            if (dev_addr_in == adc_host_pkg::ADDR_CTRL1)
               resel_q <= 1'b0;
            else if (dev_addr_in == adc_host_pkg::ADDR_CTRL0 && !dev_wdata_in[6])
               resel_q <= 1'b1;
            // only the start bit may move while started
            if (start && dev_addr_in < 8'h06 && (dev_addr_in != 8'h00 || dev_wdata_in[6]))
               viol_out <= viol_out + 1;
            if (dev_addr_in == adc_host_pkg::ADDR_CTRL1 && dev_wdata_in[6] && !ladder_on_out)
               age_q <= 1;
            if (dev_addr_in == adc_host_pkg::ADDR_CTRL0 && dev_wdata_in[6] && !start)
            begin
               if (!dev_wdata_in[5])
                  cnt_q <= span;
               if (!ladder_on_out || age_q < adc_host_pkg::REF_WAIT_CYC || r_q[18] != 8'hFF ||
                   !resel_q || r_q[4] != adc_host_pkg::CONV_DIV_CODE ||
                   r_q[17] != 8'h00 || (dev_wdata_in[5] && (dma_on || r_q[19] != 8'h00)) ||
                   (r_q[1][5:4] != 2'h0 && (r_q[2][2:1] != 2'h0 || r_q[3][1])))
                  viol_out <= viol_out + 1;
            end
            if (dev_addr_in == adc_host_pkg::ADDR_CTRL0 && !dev_wdata_in[6] && cnt_q > 0)
            begin
               cnt_q <= 0;
               res_q[idx] <= 16'hA5A5;
            end
         end
         if (dev_rd_in)
         begin
            hold_q <= 5;
            // no program reads of results under DMA
            if (dma_on && dev_addr_in[7:3] == 5'h01)
               viol_out <= viol_out + 1;
            dev_rdata_out <= (dev_addr_in[7:3] == 5'h01) ? res_q[dev_addr_in[2:0]] :
                             {8'h00, r_q[dev_addr_in[4:0]]};
         end
      end
   end
endmodule

// ==== testbench.sv ====
// Self-checking bench for the converter host sequencer
`timescale 1ns/1ps
module testbench;
   logic ref_clk_in = 1'b0;
   logic rst_n_in;
   logic cmd_start, cmd_halt, cmd_pd, dma, smp, tex, aen, akind, adir, open, slow, trig_n;
   logic [1:0] ext;
   logic [2:0] ch, mode;
   logic [9:0] level;
   wire logic busy, done, running, rvalid, rundef, wr, rd, ladder;
   wire logic [15:0] result, rdata;
   wire logic [7:0] addr, wdata;
   int viol, n_errors, check_count;

   always #50 ref_clk_in = ~ref_clk_in;

   adc_host_ctrl i_dut (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
      .cmd_start_in(cmd_start), .cmd_halt_in(cmd_halt), .cmd_power_down_in(cmd_pd),
      .cfg_ext_pin_sel_in(ext), .cfg_channel_in(ch), .cfg_op_mode_in(mode), .cfg_dma_in(dma),
      .cfg_sample_hold_in(smp), .cfg_trigger_ext_in(tex), .cfg_trig_src_in(2'b00),
      .cfg_assist_en_in(aen), .cfg_assist_kind_in(akind), .cfg_assist_dir_in(adir),
      .busy_out(busy), .done_out(done), .running_out(running), .result_out(result),
      .result_valid_out(rvalid), .result_undefined_out(rundef), .dev_addr_out(addr),
      .dev_wdata_out(wdata), .dev_wr_out(wr), .dev_rd_out(rd), .dev_rdata_in(rdata));

   adc_dev_model i_dev (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .dev_addr_in(addr),
      .dev_wdata_in(wdata), .dev_wr_in(wr), .dev_rd_in(rd), .dev_rdata_out(rdata),
      .level_in(level), .open_in(open), .slow_in(slow), .trig_n_in(trig_n),
      .ladder_on_out(ladder), .viol_out(viol));

   task automatic wrap_up();
      $display("errors=%0d checks=%0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp)
      begin
         n_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk_in);
      #1;
   endtask

   // One-cycle order: 0 start, 1 halt, 2 power down
   task automatic order(input int k);
      @(posedge ref_clk_in);
      cmd_start <= (k == 0);
      cmd_halt <= (k == 1);
      cmd_pd <= (k == 2);
      @(posedge ref_clk_in);
      cmd_start <= 1'b0;
      cmd_halt <= 1'b0;
      cmd_pd <= 1'b0;
   endtask

   // Bounded wait: 0 for done, 1 for running
   task automatic wait_for(input int which, input int lim);
      int i;
      for (i = 0; i < lim && (which == 0 ? done : running) !== 1'b1; i++)
         cyc(1);
      if ((which == 0 ? done : running) !== 1'b1)
      begin
         n_errors++;
         $display("ERROR t=%0t wait ran out got=%h exp=%h", $time,
                  (which == 0 ? done : running), 1'b1);
         wrap_up();
      end
   endtask

   function automatic logic [15:0] expect_val(input logic [9:0] lv, input logic e, k, d, o);
      if (e && (k || o))
         return d ? 16'h0000 : 16'h03FF;
      return {6'h00, lv};
   endfunction

   task automatic trig_burst();
      cyc(40);
      trig_n <= 1'b0;
      cyc(2);
      trig_n <= 1'b1;
      cyc(4);
      trig_n <= 1'b0;
      cyc(2);
      trig_n <= 1'b1;
   endtask

   task automatic run(input logic [1:0] e, input logic m, d, t, sf, wt);
      logic [31:0] r;
      r = $urandom;
      @(posedge ref_clk_in);
      ext <= e;
      mode <= {2'b00, m};
      dma <= d;
      tex <= t;
      {ch, smp, aen, akind, adir, level, slow} <= r[17:0] | {17'h0, sf};
      open <= r[18] & r[13];
      order(0);
      if (t)
         fork
            trig_burst();
         join_none
      if (!wt)
         return;
      wait_for(0, 800);
      if (!d)
      begin
         chk(result, expect_val(r[10:1], r[13], r[12], r[11], r[18] & r[13]));
         chk({15'h0, rvalid}, 16'h0001);
      end
      cyc(1);
      chk(viol[15:0], 16'h0000);
   endtask

   initial
   begin
      rst_n_in = 1'b0;
      {cmd_start, cmd_halt, cmd_pd, dma, smp, tex, aen, akind, adir, open, slow} = '0;
      trig_n = 1'b1;
      ext = 2'h0;
      ch = 3'h0;
      mode = 3'h0;
      level = 10'h000;
      void'($urandom(6));
      cyc(3);
      rst_n_in <= 1'b1;
      for (int i = 0; i < 8; i++)
         run(i[1:0], i[2], i[2], 1'b0, 1'b0, 1'b1);
      for (int i = 0; i < 10; i++)
         run(2'($urandom), 1'($urandom), 1'($urandom), 1'b0, 1'b0, 1'b1);
      run(2'h0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
      run(2'h1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
      run(2'h3, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
      order(1);
      cyc(5);
      chk({14'h0, rundef, running}, 16'h0002);
      run(2'h0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
      wait_for(1, 100);
      cyc(8);
      order(1);
      cyc(4);
      chk({13'h0, busy, rvalid, rundef}, 16'h0001);
      chk(viol[15:0], 16'h0000);
      order(2);
      cyc(4);
      chk({15'h0, ladder}, 16'h0000);
      wrap_up();
   end
endmodule
